// [fcsm_pkg.sv]
// Purpose: shared constants for the flash command interface state machine
// Assumes: 16-bit host data bus, command code in the low byte
// Notes: state codes are one-hot
package fcsm_pkg;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROG_A = 8'h10;
  localparam logic [7:0] CMD_PROG_B = 8'h40;
  localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_BUFFERED_FACTORY_PROGRAM_SETUP = 8'h80;
  localparam logic [7:0] CMD_BLANK_SETUP = 8'hBC;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_BLANK_CONFIRM = 8'hCB;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam int ERR_LSB = 3;
  localparam int ERR_W = 3;
  localparam int BANK_W = 4;
  localparam int BLOCK_W = 8;
  localparam logic [ERR_W-1:0] ERR_RESET = 3'h0;
  typedef enum logic [8:0]
  {
    FCSM_READ_ARRAY = 9'h001,
    FCSM_READY = 9'h002,
    FCSM_SETUP = 9'h004,
    FCSM_BLANK_SETUP = 9'h008,
    FCSM_BUFFERED_FACTORY_PROGRAM_SETUP = 9'h010,
    FCSM_BUFFERED_FACTORY_PROGRAM_BUSY = 9'h020,
    FCSM_ES_BP_LOAD1 = 9'h040,
    FCSM_ES_BP_LOAD2 = 9'h080,
    FCSM_ES_LOCK_SETUP = 9'h100
  } fcsm_state_e;
endpackage

// [fcsm_sync.sv]
// Purpose: two-flip-flop synchroniser, one bit per lane
// Assumes: inputs are levels from outside the sys_clk domain
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module fcsm_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [fcsm_core.sv]
// Purpose: command interface state machine of a NOR flash device
// Assumes: host write cycles arrive as a one-cycle strobe on sys_clk
// Notes: one shared state stands for the bank last addressed
`timescale 1ns/1ps
module fcsm_core
  import fcsm_pkg::*;
#(
  parameter int NBANKS = 16
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic host_we,
  input wire logic [15:0] host_data,
  input wire logic [BANK_W-1:0] host_bank,
  input wire logic [BLOCK_W-1:0] host_block,
  input wire logic pe_busy_pin,
  input wire logic pe_suspended_pin,
  input wire logic status_bit_zero,
  input wire logic [ERR_W-1:0] err_set,
  output logic [NBANKS-1:0] bank_read_array,
  output logic [NBANKS-1:0] bank_data_undefined,
  output logic [ERR_W-1:0] status_errors,
  output logic start_program,
  output logic start_buffer_program_op,
  output logic start_erase,
  output logic start_blank_check,
  output logic start_buffered_factory_program,
  output logic buffered_factory_program_data_strobe,
  output logic [15:0] buffered_factory_program_data,
  output logic buffer_program_op_fail,
  output logic sequence_error
);
  ////////////////////////////////////////////////////////////////////
  logic rst_meta;
  logic rst_sync_n;
  logic pe_busy;
  logic pe_suspended;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // controller status comes from another timing domain
  fcsm_sync #(.WIDTH(2)) u_sync
  (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .async_in({pe_busy_pin, pe_suspended_pin}),
    .sync_out({pe_busy, pe_suspended})
  );

  ////////////////////////////////////////////////////////////////////
  fcsm_state_e state;
  fcsm_state_e next_state;
  logic [NBANKS-1:0] bank_ra;
  logic [NBANKS-1:0] next_bank_ra;
  logic [ERR_W-1:0] errs;
  logic [ERR_W-1:0] next_errs;
  logic [BLOCK_W-1:0] first_block;
  logic [BLOCK_W-1:0] next_first_block;
  logic bp_mismatch;
  logic next_bp_mismatch;
  logic [7:0] pulses;
  logic [7:0] next_pulses;
  logic [15:0] next_buffered_factory_program_data;
  logic [7:0] cmd;

  assign cmd = host_data[7:0];

  always_comb
  begin
    next_state = state;
    next_bank_ra = bank_ra;
    next_first_block = first_block;
    next_bp_mismatch = bp_mismatch;
    next_pulses = 8'h00;
    next_buffered_factory_program_data = buffered_factory_program_data;
    // set wins over clear: new errors are OR-ed in after any clear
    next_errs = errs;
    if (host_we && state != FCSM_BUFFERED_FACTORY_PROGRAM_BUSY && cmd == CMD_CLEAR_STATUS &&
        !pe_busy && !pe_suspended)
    begin
      next_errs = ERR_RESET;
    end
    next_errs = next_errs | err_set;
    if (host_we)
    begin
      if (state != FCSM_BUFFERED_FACTORY_PROGRAM_BUSY)
      begin
        next_bank_ra[host_bank] = (cmd == CMD_READ_ARRAY);
      end
      case (state)
        FCSM_READ_ARRAY, FCSM_READY:
        begin
          next_state = FCSM_READY;
          if (cmd == CMD_READ_ARRAY)
          begin
            next_state = FCSM_READ_ARRAY;
          end
          else if (pe_suspended && cmd == CMD_BUF_PROG)
          begin
            next_first_block = host_block;
            next_bp_mismatch = 1'b0;
            next_state = FCSM_ES_BP_LOAD1;
          end
          else if (pe_suspended && cmd == CMD_LOCK_SETUP)
          begin
            next_state = FCSM_ES_LOCK_SETUP;
          end
          else if (pe_busy && (cmd == CMD_PROG_A || cmd == CMD_PROG_B ||
                   cmd == CMD_BUF_PROG || cmd == CMD_ERASE))
          begin
            next_state = state;
          end
          else if (cmd == CMD_PROG_A || cmd == CMD_PROG_B ||
                   cmd == CMD_ERASE || cmd == CMD_BUF_PROG)
          begin
            next_first_block = host_block;
            next_buffered_factory_program_data = host_data;
            next_state = FCSM_SETUP;
          end
          else if (cmd == CMD_BLANK_SETUP)
          begin
            next_state = FCSM_BLANK_SETUP;
          end
          else if (cmd == CMD_BUFFERED_FACTORY_PROGRAM_SETUP)
          begin
            if (!status_bit_zero)
            begin
              next_first_block = host_block;
              next_state = FCSM_BUFFERED_FACTORY_PROGRAM_SETUP;
            end
            else
            begin
              next_pulses[6] = 1'b1;
            end
          end
        end
        FCSM_SETUP:
        begin
          next_state = FCSM_READY;
          if (!pe_busy)
          begin
            next_pulses[0] = (buffered_factory_program_data[7:0] != CMD_ERASE) &&
                             (buffered_factory_program_data[7:0] != CMD_BUF_PROG);
            next_pulses[1] = (buffered_factory_program_data[7:0] == CMD_BUF_PROG);
            next_pulses[2] = (buffered_factory_program_data[7:0] == CMD_ERASE) &&
                             (cmd == CMD_CONFIRM);
            next_pulses[6] = (buffered_factory_program_data[7:0] == CMD_ERASE) &&
                             (cmd != CMD_CONFIRM);
          end
        end
        FCSM_BLANK_SETUP:
        begin
          next_state = FCSM_READY;
          next_pulses[3] = (cmd == CMD_BLANK_CONFIRM);
          next_pulses[6] = (cmd != CMD_BLANK_CONFIRM);
        end
        FCSM_BUFFERED_FACTORY_PROGRAM_SETUP:
        begin
          next_state = FCSM_READY;
          if (cmd == CMD_CONFIRM)
          begin
            next_state = FCSM_BUFFERED_FACTORY_PROGRAM_BUSY;
            next_pulses[4] = 1'b1;
          end
          else
          begin
            next_pulses[6] = 1'b1;
          end
        end
        FCSM_BUFFERED_FACTORY_PROGRAM_BUSY:
        begin
          // every code is data here; leave by writing another block
          if (host_block == first_block)
          begin
            next_buffered_factory_program_data = host_data;
            next_pulses[5] = 1'b1;
          end
          else
          begin
            next_state = FCSM_READY;
          end
        end
        FCSM_ES_BP_LOAD1:
        begin
          next_state = FCSM_ES_BP_LOAD2;
          if (host_block != first_block)
          begin
            next_bp_mismatch = 1'b1;
          end
        end
        FCSM_ES_BP_LOAD2:
        begin
          if (host_block != first_block)
          begin
            next_bp_mismatch = 1'b1;
          end
          if (cmd == CMD_CONFIRM)
          begin
            next_state = FCSM_READY;
            next_pulses[1] = !(bp_mismatch || host_block != first_block);
            next_pulses[7] = bp_mismatch || host_block != first_block;
          end
        end
        FCSM_ES_LOCK_SETUP:
        begin
          next_state = FCSM_READY;
          next_pulses[6] = (cmd != CMD_CONFIRM);
        end
        default:
        begin
          next_state = FCSM_READ_ARRAY;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state <= FCSM_READ_ARRAY;
      bank_ra <= '1;
      errs <= ERR_RESET;
      first_block <= '0;
      bp_mismatch <= 1'b0;
      pulses <= 8'h00;
      buffered_factory_program_data <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      bank_ra <= next_bank_ra;
      errs <= next_errs;
      first_block <= next_first_block;
      bp_mismatch <= next_bp_mismatch;
      pulses <= next_pulses;
      buffered_factory_program_data <= next_buffered_factory_program_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // a bank in read array while the controller runs reads garbage
  assign bank_read_array = bank_ra;
  assign bank_data_undefined = pe_busy ? bank_ra : '0;
  assign status_errors = errs;
  // failure has its own pulse so a plain program in suspend still starts
  assign start_program = pulses[0];
  assign buffer_program_op_fail = pulses[7];
  assign start_buffer_program_op = pulses[1];
  assign start_erase = pulses[2];
  assign start_blank_check = pulses[3];
  assign start_buffered_factory_program = pulses[4];
  assign buffered_factory_program_data_strobe = pulses[5];
  assign sequence_error = pulses[6];
endmodule

// [fcsm_asserts.sv]
// Purpose: port checks of the command state machine
// Assumes: bound to fcsm_core, one clock domain
// Notes: busy and suspend pins must settle through the synchroniser
`timescale 1ns/1ps
module fcsm_core_asserts
  import fcsm_pkg::*;
#(
  parameter int NBANKS = 16
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic host_we,
  input wire logic [15:0] host_data,
  input wire logic [BLOCK_W-1:0] host_block,
  input wire logic pe_busy_pin,
  input wire logic pe_suspended_pin,
  input wire logic status_bit_zero,
  input wire logic [ERR_W-1:0] err_set,
  input wire logic [NBANKS-1:0] bank_read_array,
  input wire logic [NBANKS-1:0] bank_data_undefined,
  input wire logic [ERR_W-1:0] status_errors,
  input wire logic start_program,
  input wire logic start_buffer_program_op,
  input wire logic start_erase,
  input wire logic start_buffered_factory_program,
  input wire logic buffered_factory_program_data_strobe,
  input wire logic [15:0] buffered_factory_program_data,
  input wire logic buffer_program_op_fail
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] prev_cmd;
  logic prev_sr0;
  logic buffered_factory_program_on;
  logic [BLOCK_W-1:0] buffered_factory_program_blk;
  wire logic [7:0] cmd = host_data[7:0];
  wire logic idle = !pe_busy_pin && !pe_suspended_pin;
  // codes written during factory program are data, never a clear
  wire logic in_buffered_factory_program = start_buffered_factory_program || buffered_factory_program_on;
  wire logic clr = host_we && cmd == CMD_CLEAR_STATUS && err_set == '0 &&
    !in_buffered_factory_program;
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_cmd <= 8'h00;
      prev_sr0 <= 1'b0;
      buffered_factory_program_on <= 1'b0;
      buffered_factory_program_blk <= '0;
    end
    else
    begin
      if (host_we)
      begin
        prev_cmd <= cmd;
        prev_sr0 <= status_bit_zero;
      end
      if (host_we && !in_buffered_factory_program && cmd == CMD_BUFFERED_FACTORY_PROGRAM_SETUP)
      begin
        buffered_factory_program_blk <= host_block;
      end
      buffered_factory_program_on <= in_buffered_factory_program && !(host_we && host_block != buffered_factory_program_blk);
    end
  end
  ////////////////////////////////////////////////////////////////////
  AST_RESET_READ: assert property (
    $rose(rst_n) |-> &bank_read_array)
    else $error("banks not in read array after reset");
  AST_UNDEF_SUB: assert property (
    (bank_data_undefined & ~bank_read_array) == '0)
    else $error("undefined data outside read array");
  AST_UNDEF_IDLE: assert property (
    (!pe_busy_pin)[*4] |-> bank_data_undefined == '0)
    else $error("undefined data while idle");
  AST_BUSY_IGNORE: assert property (
    pe_busy_pin[*4] |=>
    !(start_program || start_buffer_program_op || start_erase))
    else $error("operation started while busy");
  AST_CLEAR: assert property (
    idle[*4] ##0 clr |=> status_errors == ERR_RESET)
    else $error("clear status left errors");
  AST_CLEAR_HELD: assert property (
    (!idle)[*4] ##0 clr |=> $stable(status_errors))
    else $error("errors cleared while busy");
  AST_BUFFERED_FACTORY_PROGRAM_REFUSE: assert property (
    start_buffered_factory_program |->
    $past(prev_cmd) == CMD_BUFFERED_FACTORY_PROGRAM_SETUP && !$past(prev_sr0))
    else $error("factory program started with status bit set");
  AST_BUFFERED_FACTORY_PROGRAM_DATA: assert property (
    buffered_factory_program_data_strobe |-> $past(host_we) && buffered_factory_program_data == $past(host_data))
    else $error("factory data not the written word");
  AST_BP_FAIL: assert property (
    buffer_program_op_fail |-> $past(host_we) &&
    $past(cmd) == CMD_CONFIRM && !start_buffer_program_op)
    else $error("buffer program fail without confirm");
  cover property (start_erase);
  cover property (buffered_factory_program_data_strobe);
  cover property (buffer_program_op_fail);
endmodule

// [fcsm_host.sv]
// Purpose: host model issuing write cycles
// Assumes: drives at falling edges, one write per two cycles
// Notes: released data bus shows the inverse of the last word
`timescale 1ns/1ps
module fcsm_host
  import fcsm_pkg::*;
(
  input wire logic sys_clk,
  output logic host_we,
  output logic [15:0] host_data,
  output logic [BANK_W-1:0] host_bank,
  output logic [BLOCK_W-1:0] host_block
);
  initial
  begin
    host_we = 1'b0;
    host_data = 16'h0000;
    host_bank = '0;
    host_block = '0;
  end
  // bank is held after the write so pairs stay in one bank
  task automatic wr(input logic [15:0] d, input logic [BANK_W-1:0] bk,
    input logic [BLOCK_W-1:0] bl);
    @(negedge sys_clk);
    host_we = 1'b1;
    host_data = d;
    host_bank = bk;
    host_block = bl;
    @(negedge sys_clk);
    host_we = 1'b0;
    host_data = ~d;
  endtask
endmodule

// [flash_command_state_machine_test.sv]
// Purpose: self-checking bench of the command state machine
// Assumes: outputs looked at at the falling edge after a write
// Notes: busy and suspend settle within two cycles; the bench waits four
`timescale 1ns/1ps
module flash_command_state_machine_test;
  import fcsm_pkg::*;
  localparam int NBANKS = 16;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pe_busy_pin = 1'b0;
  logic pe_suspended_pin = 1'b0;
  logic status_bit_zero = 1'b0;
  logic [ERR_W-1:0] err_set = '0;
  logic host_we;
  logic [15:0] host_data, buffered_factory_program_data;
  logic [BANK_W-1:0] host_bank;
  logic [BLOCK_W-1:0] host_block;
  logic [NBANKS-1:0] bank_read_array, bank_data_undefined;
  logic [ERR_W-1:0] status_errors;
  logic start_program, start_buffer_program_op, start_erase;
  logic start_blank_check, start_buffered_factory_program, buffered_factory_program_data_strobe;
  logic buffer_program_op_fail, sequence_error;
  int num_errors = 0;
  int n_compared = 0;
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  fcsm_host i_fcsm_host(.sys_clk(sys_clk), .host_we(host_we),
    .host_data(host_data), .host_bank(host_bank), .host_block(host_block));
  fcsm_core #(.NBANKS(NBANKS)) i_fcsm_core(.*);
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic hold(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic finish_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_busy();
    @(negedge sys_clk);
    err_set = 3'h2;
    @(negedge sys_clk);
    err_set = '0;
    pe_busy_pin = 1'b1;
    hold(4);
    i_fcsm_host.wr(16'h0020, 1, 0);
    i_fcsm_host.wr(16'h00D0, 1, 0);
    chk("erase_busy", 0, start_erase);
    i_fcsm_host.wr(16'h00FF, 2, 0);
    chk("undef", 1, bank_data_undefined[2]);
    i_fcsm_host.wr(16'h0050, 2, 0);
    chk("err_held", 2, status_errors);
    pe_busy_pin = 1'b0;
    hold(4);
    i_fcsm_host.wr(16'h0050, 2, 0);
    chk("err_clr", 0, status_errors);
    i_fcsm_host.wr(16'h0020, 1, 0);
    i_fcsm_host.wr(16'h00D0, 1, 0);
    chk("erase", 1, start_erase);
  endtask
  task automatic t_buffered_factory_program();
    status_bit_zero = 1'b1;
    i_fcsm_host.wr(16'h0080, 0, 7);
    chk("buffered_factory_program_refused", 1, sequence_error);
    status_bit_zero = 1'b0;
    i_fcsm_host.wr(16'h0080, 0, 7);
    i_fcsm_host.wr(16'h00D0, 0, 7);
    chk("buffered_factory_program_start", 1, start_buffered_factory_program);
    i_fcsm_host.wr(16'h0070, 0, 7);
    chk("buffered_factory_program_strobe", 1, buffered_factory_program_data_strobe);
    chk("buffered_factory_program_data", 16'h0070, buffered_factory_program_data);
    i_fcsm_host.wr(16'h1234, 0, 9);
    chk("buffered_factory_program_other", 0, buffered_factory_program_data_strobe);
    i_fcsm_host.wr(16'h00FF, 0, 0);
  endtask
  task automatic t_bp_es();
    pe_suspended_pin = 1'b1;
    hold(4);
    i_fcsm_host.wr(16'h00E8, 0, 3);
    i_fcsm_host.wr(16'h0002, 0, 3);
    i_fcsm_host.wr(16'h5555, 0, 5);
    i_fcsm_host.wr(16'h00D0, 0, 3);
    chk("bp_fail", 1, buffer_program_op_fail);
    i_fcsm_host.wr(16'h00E8, 0, 3);
    i_fcsm_host.wr(16'h0002, 0, 3);
    i_fcsm_host.wr(16'hAAAA, 0, 3);
    i_fcsm_host.wr(16'h00D0, 0, 3);
    chk("bp_ok", 1, start_buffer_program_op);
    chk("bp_nofail", 0, buffer_program_op_fail);
    i_fcsm_host.wr(16'h0040, 0, 3);
    i_fcsm_host.wr(16'h1234, 0, 3);
    chk("prog_es", 1, start_program);
    chk("prog_es_nofail", 0, buffer_program_op_fail);
    i_fcsm_host.wr(16'h00BC, 0, 3);
    i_fcsm_host.wr(16'h00CB, 0, 3);
    chk("blank", 1, start_blank_check);
    pe_suspended_pin = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    hold(6);
    rst_n = 1'b1;
    hold(3);
    chk("read_array", 16'hFFFF, bank_read_array);
    t_busy();
    t_buffered_factory_program();
    t_bp_es();
    finish_test();
  end
  initial
  begin
    #100us;
    num_errors++;
    finish_test();
  end
endmodule
bind fcsm_core fcsm_core_asserts #(.NBANKS(NBANKS)) i_fcsm_core_asserts(.*);
